// ### verilog/fsp_pkg.sv
// Purpose: shared constants for the fault status and power-ok block
// Assumes: one 100 MHz system clock
// Notes:   command codes double as register offsets
package fsp_pkg;
  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_ALL_STATUS_SNAPSHOT = 8'hdb;
  localparam logic [7:0] CMD_PER_PHASE_FAULT     = 8'hdc;
  localparam logic [7:0] CMD_PWR_OK_SETTINGS     = 8'he3;

  // ----------------------------------------------------------------
  // snapshot byte positions (low bit of each byte)
  // ----------------------------------------------------------------
  localparam int SNAP_VENDOR_LSB = 48;
  localparam int SNAP_OTHER_LSB  = 40;
  localparam int SNAP_COMM_LSB   = 32;
  localparam int SNAP_TEMP_LSB   = 24;
  localparam int SNAP_INPUT_LSB  = 16;
  localparam int SNAP_LOAD_LSB   = 8;
  localparam int SNAP_OUTV_LSB   = 0;
  localparam int SNAP_W          = 56;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int INVALID_CMD_BIT = 7;
  localparam int COMM_FAULT_BIT  = 1;
  localparam int OFF_DELAY_LSB   = 12;
  localparam int ON_DELAY_LSB    = 8;
  localparam int MASK_W          = 8;
  localparam int NUM_PHASES      = 4;

  // ----------------------------------------------------------------
  // selector values and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  PHASE_ALL      = 8'hff;
  localparam logic [7:0]  PHASE_ALL_ALT  = 8'h80;
  localparam logic [15:0] PG_CFG_RESET   = 16'h0000;
  localparam logic [3:0]  PHASE_RESET    = 4'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_HZ     = 100_000_000;
  localparam int PWM_CLK_HZ     = 500_000;
  localparam int PWM_DIV_CYCLES = SYS_CLK_HZ / PWM_CLK_HZ;
  localparam int DELAY_W        = 16;

  // 0 gives one tick, n gives 2^n+1 ticks
  function automatic logic [DELAY_W-1:0] delay_ticks(input logic [3:0] sel);
    logic [DELAY_W-1:0] r;
    r = 16'h0001;
    if (sel != 4'h0) begin
      r = (16'h0001 << sel) + 16'h0001;
    end
    return r;
  endfunction : delay_ticks
endpackage : fsp_pkg

// ### verilog/fsp_timer_if.sv
// Purpose: carrier between the power-ok logic and one delay timer
// Assumes: all signals on the system clock
// Notes:   one instance per timer
`timescale 1ns/100ps
interface fsp_timer_if;
  logic       tick;
  logic       run;
  logic [3:0] sel;
  logic       done;
  modport ctrl  (output tick, output run, output sel, input done);
  modport timer (input tick, input run, input sel, output done);
endinterface : fsp_timer_if

// ### verilog/fsp_tick_div.sv
// Purpose: pwm clock tick from the system clock
// Assumes: DIV of at least one
// Notes:   one-cycle enable pulse, no second clock
`timescale 1ns/100ps
module fsp_tick_div #(
  parameter int DIV = fsp_pkg::PWM_DIV_CYCLES
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // tick out
  output logic      tick
);
  // the counter is sixteen bits wide
  if (DIV < 1 || DIV > 65536) begin : g_bad_div
    $error("fsp_tick_div: DIV out of range");
  end

  logic [15:0] cnt_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
    end else if (cnt_q == 16'(DIV - 1)) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick  <= 1'b0;
    end
  end
endmodule : fsp_tick_div

// ### verilog/fsp_delay_timer.sv
// Purpose: counts pwm ticks up to a coded delay
// Assumes: run held high for the whole wait
// Notes:   done stays high until run drops
`timescale 1ns/100ps
module fsp_delay_timer (
  // clock and reset
  input  wire logic  clk,
  input  wire logic  rst_n,
  // control
  fsp_timer_if.timer t
);
  logic [fsp_pkg::DELAY_W-1:0] cnt_q;
  logic [fsp_pkg::DELAY_W-1:0] target;

  assign target = fsp_pkg::delay_ticks(t.sel);

  // dropping run restarts the count from zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= '0;
      t.done <= 1'b0;
    end else if (!t.run) begin
      cnt_q  <= '0; // RL17
      t.done <= 1'b0; // RL18
    end else if (t.tick && !t.done) begin
      cnt_q <= cnt_q + 16'h0001; // RL18
      if (cnt_q + 16'h0001 >= target) begin
        t.done <= 1'b1;
      end
    end
  end
endmodule : fsp_delay_timer

// ### verilog/fsp_fault_pg.sv
// Purpose: status snapshot, per-phase fault word and power-ok control
// Assumes: command strobes and status inputs come from logic on SYS_CLK
// Notes:   settings load from non-volatile storage on NVM_LOAD
//
// What this block does
// RL1: write to read-only command sets comm fault and invalid-command flag, alerts host
// RL2: snapshot returns seven live status bytes, vendor at top, output volt at bottom
// RL3: writes to the snapshot never clear any status flag
// RL4: selector FFh or 80h returns one fault bit per phase
// RL5: other selector returns bit 0 set if selected phase reports anything
// RL6: unassigned or disabled phase bits always read zero
// RL7: phase bits 3:0 hold faults, 15:4 read zero, reset to zero
// RL8: fault-to-low delay field 15:12, 0 is 1 tick, N is 2^N+1 ticks
// RL9: clear-to-release delay field 11:8, same coding
// RL10: mask bit 0 lets its event pull power-ok low, 1 blocks it
// RL11: power-ok low while disabled, ramping, waiting, or in fault shutdown
// RL12: fault-to-low delay skipped during turn-off ramp or fault shutdown
// RL13: unmasked fault acts unless its response is continue without interruption
// RL14: both delays timed independently; short events may not drop power-ok
// RL15: settings writable only with conversion disabled, else read-only
// RL16: host uses word writes and reads for phase word and settings
// RL17: one combined event signal starts delays, restarting on each change
// RL18: delay counters advance once per pwm tick and hold when done, resetting only when run drops
`timescale 1ns/100ps
module fsp_fault_pg #(
  parameter int PWM_DIV = fsp_pkg::PWM_DIV_CYCLES
) (
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RSTN,
  // command port
  input  wire logic [7:0]  CMD_CODE,
  input  wire logic        CMD_WR,
  input  wire logic [15:0] CMD_WDATA,
  input  wire logic        CMD_RD,
  output logic [55:0]      CMD_RDATA,
  output logic             CMD_RVALID,
  input  wire logic        CLEAR_FAULTS,
  // class status bytes
  input  wire logic [7:0]  VENDOR_STATUS_BYTE,
  input  wire logic [7:0]  OTHER_STATUS_BYTE,
  input  wire logic [7:0]  COMM_STATUS_BYTE,
  input  wire logic [7:0]  TEMP_STATUS_BYTE,
  input  wire logic [7:0]  INPUT_STATUS_BYTE,
  input  wire logic [7:0]  LOAD_CURRENT_STATUS_BYTE,
  input  wire logic [7:0]  OUTPUT_VOLT_STATUS_BYTE,
  // comm summary and host notice
  output logic             COMM_FAULT_BIT,
  output logic             HOST_ALERT_N,
  // phases
  input  wire logic [7:0]  PHASE_SEL,
  input  wire logic [3:0]  PHASE_REPORTS,
  input  wire logic [3:0]  PHASE_ASSIGNED,
  // settings store
  input  wire logic        NVM_LOAD,
  input  wire logic [15:0] NVM_PWR_OK_SETTINGS,
  // events, in mask bit order
  input  wire logic [7:0]  PG_EVENTS,
  input  wire logic [7:0]  PG_EVENT_CONTINUE,
  // power sequence
  input  wire logic        CONV_EN,
  input  wire logic        TURN_ON_WAIT,
  input  wire logic        TURN_ON_RAMP,
  input  wire logic        TURN_OFF_RAMP,
  input  wire logic        FAULT_SHUTDOWN,
  // power ok
  output logic             POWER_OK_OUTPUT
);
  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  // pwm divider reuses the sixteen-bit tick counter
  if (PWM_DIV < 1 || PWM_DIV > 65536) begin : g_bad_div
    $error("fsp_fault_pg: PWM_DIV out of range");
  end

  // phase decode and mask map are fixed at four phases, eight events
  if (fsp_pkg::NUM_PHASES != 4 || fsp_pkg::MASK_W != 8) begin : g_bad_map
    $error("fsp_fault_pg: phase count or mask width unsupported");
  end

  // the longest coded delay, 2^15+1 ticks, needs sixteen counter bits
  if (fsp_pkg::DELAY_W < 16) begin : g_bad_delay
    $error("fsp_fault_pg: delay counter too narrow");
  end

  // ----------------------------------------------------------------
  // pwm tick
  // ----------------------------------------------------------------
  logic pwm_tick;

  fsp_tick_div #(
    .DIV (PWM_DIV)
  ) u_div (
    .clk   (SYS_CLK),
    .rst_n (RSTN),
    .tick  (pwm_tick)
  );

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  logic        wr_snapshot;
  logic        wr_phase;
  logic        wr_settings;
  logic        wr_settings_ok;
  logic        wr_invalid;

  assign wr_snapshot    = CMD_WR && (CMD_CODE == fsp_pkg::CMD_ALL_STATUS_SNAPSHOT); // RL3
  assign wr_phase       = CMD_WR && (CMD_CODE == fsp_pkg::CMD_PER_PHASE_FAULT);
  assign wr_settings    = CMD_WR && (CMD_CODE == fsp_pkg::CMD_PWR_OK_SETTINGS);
  assign wr_settings_ok = wr_settings && !CONV_EN; // RL15
  // settings turn read-only while converting
  assign wr_invalid     = wr_snapshot || (wr_settings && CONV_EN); // RL1 RL15

  // ----------------------------------------------------------------
  // invalid command flag
  // ----------------------------------------------------------------
  logic invalid_cmd_q;

  // set wins over clear so a coincident bad write is not lost
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      invalid_cmd_q <= 1'b0;
    end else if (wr_invalid) begin
      invalid_cmd_q <= 1'b1; // RL1
    end else if (CLEAR_FAULTS) begin
      invalid_cmd_q <= 1'b0;
    end
  end

  // flag folded into the live comm byte, so reads and summary agree
  logic [7:0] comm_byte;

  always_comb begin
    comm_byte = COMM_STATUS_BYTE;
    comm_byte[fsp_pkg::INVALID_CMD_BIT] = COMM_STATUS_BYTE[fsp_pkg::INVALID_CMD_BIT]
                                          | invalid_cmd_q; // RL1
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      COMM_FAULT_BIT <= 1'b0;
      HOST_ALERT_N   <= 1'b1;
    end else begin
      COMM_FAULT_BIT <= |comm_byte; // RL1
      HOST_ALERT_N   <= ~(|comm_byte); // RL1
    end
  end

  // ----------------------------------------------------------------
  // per-phase fault word
  // ----------------------------------------------------------------
  logic [3:0] phase_fault_q;

  // sticky per phase; writing 1 clears, a new report wins
  for (genvar gi = 0; gi < fsp_pkg::NUM_PHASES; gi++) begin : g_phase
    logic hit_q;

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
      if (!RSTN) begin
        hit_q <= fsp_pkg::PHASE_RESET[gi]; // RL7
      end else if (PHASE_REPORTS[gi]) begin
        hit_q <= 1'b1;
      end else if ((wr_phase && CMD_WDATA[gi]) || CLEAR_FAULTS) begin
        hit_q <= 1'b0;
      end
    end

    assign phase_fault_q[gi] = hit_q;
  end

  logic [15:0] phase_word;
  logic [3:0]  phase_live;

  assign phase_live = phase_fault_q & PHASE_ASSIGNED; // RL6

  always_comb begin
    phase_word = 16'h0000; // RL7
    if (PHASE_SEL == fsp_pkg::PHASE_ALL || PHASE_SEL == fsp_pkg::PHASE_ALL_ALT) begin
      phase_word[3:0] = phase_live; // RL4
    end else if (PHASE_SEL < 8'(fsp_pkg::NUM_PHASES)) begin
      phase_word[0] = phase_live[PHASE_SEL[1:0]]; // RL5
    end
  end

  // ----------------------------------------------------------------
  // power-ok settings
  // ----------------------------------------------------------------
  logic [15:0] settings_q;

  // a store load beats a host write in the same cycle
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      settings_q <= fsp_pkg::PG_CFG_RESET;
    end else if (NVM_LOAD) begin
      settings_q <= NVM_PWR_OK_SETTINGS;
    end else if (wr_settings_ok) begin
      settings_q <= CMD_WDATA; // RL15
    end
  end

  logic [3:0] off_sel;
  logic [3:0] on_sel;
  logic [7:0] pg_mask;

  assign off_sel = settings_q[fsp_pkg::OFF_DELAY_LSB +: 4]; // RL8
  assign on_sel  = settings_q[fsp_pkg::ON_DELAY_LSB +: 4]; // RL9
  assign pg_mask = settings_q[fsp_pkg::MASK_W-1:0];

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // word reads return zero above bit 15
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      CMD_RDATA  <= '0;
      CMD_RVALID <= 1'b0;
    end else begin
      CMD_RVALID <= CMD_RD;
      if (CMD_RD) begin
        case (CMD_CODE)
          fsp_pkg::CMD_ALL_STATUS_SNAPSHOT: begin
            CMD_RDATA <= {VENDOR_STATUS_BYTE, OTHER_STATUS_BYTE, comm_byte,
                          TEMP_STATUS_BYTE, INPUT_STATUS_BYTE,
                          LOAD_CURRENT_STATUS_BYTE, OUTPUT_VOLT_STATUS_BYTE}; // RL2
          end
          fsp_pkg::CMD_PER_PHASE_FAULT: begin
            CMD_RDATA <= {40'h0, phase_word}; // RL16
          end
          fsp_pkg::CMD_PWR_OK_SETTINGS: begin
            CMD_RDATA <= {40'h0, settings_q}; // RL16
          end
          default: begin
            CMD_RDATA <= '0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // event combine
  // ----------------------------------------------------------------
  logic pg_event;
  logic forced_low;
  logic bypass_off;

  // continue-without-interruption events never count
  assign pg_event   = |(PG_EVENTS & ~pg_mask & ~PG_EVENT_CONTINUE); // RL10 RL13 RL17
  assign forced_low = !CONV_EN || TURN_ON_WAIT || TURN_ON_RAMP
                      || TURN_OFF_RAMP || FAULT_SHUTDOWN; // RL11
  assign bypass_off = TURN_OFF_RAMP || FAULT_SHUTDOWN; // RL12

  // ----------------------------------------------------------------
  // delay timers
  // ----------------------------------------------------------------
  fsp_timer_if off_if ();
  fsp_timer_if on_if ();

  logic pg_q;

  // each timer sees only its own condition
  // done holds until pg_q flips and drops run
  assign off_if.tick = pwm_tick;
  assign off_if.sel  = off_sel;
  assign off_if.run  = pg_q && pg_event; // RL14 RL17
  assign on_if.tick  = pwm_tick;
  assign on_if.sel   = on_sel;
  assign on_if.run   = !pg_q && !pg_event && !forced_low; // RL14 RL17

  fsp_delay_timer u_off_tmr (
    .clk   (SYS_CLK),
    .rst_n (RSTN),
    .t     (off_if.timer)
  );

  fsp_delay_timer u_on_tmr (
    .clk   (SYS_CLK),
    .rst_n (RSTN),
    .t     (on_if.timer)
  );

  // ----------------------------------------------------------------
  // power-ok state
  // ----------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pg_q <= 1'b0;
    end else if (forced_low) begin
      pg_q <= 1'b0; // RL11
    end else if (pg_q && pg_event && bypass_off) begin
      pg_q <= 1'b0; // RL12
    end else if (pg_q && off_if.done) begin
      pg_q <= 1'b0; // RL8
    end else if (!pg_q && on_if.done) begin
      pg_q <= 1'b1; // RL9
    end
  end

  // ----------------------------------------------------------------
  // power-ok pin
  // ----------------------------------------------------------------
  // gated here so a forced-low input drops the pin in the same cycle
  assign POWER_OK_OUTPUT = pg_q && !forced_low; // RL11
endmodule : fsp_fault_pg

// ### test/fsp_host_model.sv
// Purpose: host controller model driving the command port
// Assumes: strobes launched at the falling edge
// Notes:   released lines show the inverse of the last value
`timescale 1ns/100ps
module fsp_host_model (
  // clock
  input  wire logic        clk,
  // command port
  output logic [7:0]       cmd_code,
  output logic             cmd_wr,
  output logic [15:0]      cmd_wdata,
  output logic             cmd_rd,
  input  wire logic [55:0] cmd_rdata,
  input  wire logic        cmd_rvalid
);
  initial begin
    cmd_code = 8'h00;
    cmd_wr = 1'b0;
    cmd_wdata = 16'h0000;
    cmd_rd = 1'b0;
  end
  // --
  // word transfers only
  // --
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    @(negedge clk);
    cmd_code = c;
    cmd_wdata = d;
    cmd_wr = 1'b1;
    @(negedge clk);
    cmd_wr = 1'b0;
    cmd_code = ~c;
    cmd_wdata = ~d;
  endtask : wr
  // code held until the answer is taken
  task automatic rd(input logic [7:0] c, output logic [55:0] q);
    int i;
    @(negedge clk);
    cmd_code = c;
    cmd_rd = 1'b1;
    @(negedge clk);
    cmd_rd = 1'b0;
    for (i = 0; i < 4 && cmd_rvalid !== 1'b1; i++) @(negedge clk);
    q = (cmd_rvalid === 1'b1) ? cmd_rdata : 'x;
    cmd_code = ~c;
  endtask : rd
endmodule : fsp_host_model

// ### test/fsp_fault_pg_sva.sv
// Purpose: port checks of the fault status and power-ok block
// Assumes: one clock, async active-low reset
// Notes:   bound to every instance of the top module
`timescale 1ns/100ps
module fsp_fault_pg_sva #(
  parameter int PWM_DIV = 200
) (
  // clock and reset
  input wire logic        SYS_CLK,
  input wire logic        RSTN,
  // command port
  input wire logic [7:0]  CMD_CODE,
  input wire logic        CMD_WR,
  input wire logic        CMD_RD,
  input wire logic [55:0] CMD_RDATA,
  input wire logic        CMD_RVALID,
  input wire logic        CLEAR_FAULTS,
  input wire logic        COMM_FAULT_BIT,
  input wire logic        HOST_ALERT_N,
  // phases
  input wire logic [7:0]  PHASE_SEL,
  input wire logic [3:0]  PHASE_ASSIGNED,
  // power sequence
  input wire logic        CONV_EN,
  input wire logic        TURN_ON_WAIT,
  input wire logic        TURN_ON_RAMP,
  input wire logic        TURN_OFF_RAMP,
  input wire logic        FAULT_SHUTDOWN,
  input wire logic        POWER_OK_OUTPUT
);
  // --
  // assertions
  // --
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RSTN);
  read_answer_a: assert property (CMD_RVALID == $past(CMD_RD))
    else $error("read valid off");
  phase_resvd_a: assert property (CMD_RD && CMD_CODE == 8'hdc |=> CMD_RDATA[55:4] == '0)
    else $error("phase word upper bits set");
  phase_unused_a: assert property (CMD_RD && CMD_CODE == 8'hdc && PHASE_SEL == 8'hff
    |=> (CMD_RDATA[3:0] & ~$past(PHASE_ASSIGNED)) == 4'h0) else $error("unused phase set");
  one_phase_a: assert property (CMD_RD && CMD_CODE == 8'hdc && PHASE_SEL < 8'h80
    |=> CMD_RDATA[3:1] == 3'h0) else $error("single phase read wide");
  ro_write_flag_a: assert property (CMD_WR && CMD_CODE == 8'hdb && !CLEAR_FAULTS
    ##1 !CLEAR_FAULTS |=> COMM_FAULT_BIT && !HOST_ALERT_N) else $error("no comm fault");
  locked_cfg_a: assert property (CMD_WR && CMD_CODE == 8'he3 && CONV_EN && !CLEAR_FAULTS
    ##1 !CLEAR_FAULTS |=> COMM_FAULT_BIT) else $error("locked write not flagged");
  alert_level_a: assert property (HOST_ALERT_N != COMM_FAULT_BIT)
    else $error("alert disagrees");
  forced_low_a: assert property (!CONV_EN || TURN_ON_WAIT || TURN_ON_RAMP
    || TURN_OFF_RAMP || FAULT_SHUTDOWN |-> !POWER_OK_OUTPUT) else $error("power ok high");
  reset_state_a: assert property ($rose(RSTN) |-> CMD_RDATA == '0
    && !POWER_OK_OUTPUT && HOST_ALERT_N) else $error("bad reset state");
endmodule : fsp_fault_pg_sva

bind fsp_fault_pg fsp_fault_pg_sva #(.PWM_DIV(PWM_DIV)) fsp_fault_pg_sva_inst (
  .SYS_CLK, .RSTN, .CMD_CODE, .CMD_WR, .CMD_RD, .CMD_RDATA, .CMD_RVALID, .CLEAR_FAULTS,
  .COMM_FAULT_BIT, .HOST_ALERT_N, .PHASE_SEL, .PHASE_ASSIGNED, .CONV_EN, .TURN_ON_WAIT,
  .TURN_ON_RAMP, .TURN_OFF_RAMP, .FAULT_SHUTDOWN, .POWER_OK_OUTPUT
);

// ### test/fsp_fault_pg_test.sv
// Purpose: self-checking bench for the fault status and power-ok block
// Assumes: pwm tick every DIV system clocks
// Notes:   status values from a fixed-seed xorshift
`timescale 1ns/100ps
module fsp_fault_pg_test;
  // --
  // signals
  // --
  localparam int DIV = 2;
  logic        clk, rstn, clr, nvm, conv, inv, cfb, alert_n, pg, wr, rd, rv;
  logic [7:0]  code, sel, ev, cont;
  logic [15:0] wd, nvd;
  logic [55:0] st, rdat, q;
  logic [3:0]  rep, asg, seqv, stk, w;
  logic [31:0] seed;
  logic [7:0]  sels [7] = '{8'hff, 8'h80, 8'h00, 8'h01, 8'h02, 8'h03, 8'h10};
  int          failures, n_checks, k, j;

  fsp_host_model host (
    .clk(clk), .cmd_code(code), .cmd_wr(wr), .cmd_wdata(wd), .cmd_rd(rd),
    .cmd_rdata(rdat), .cmd_rvalid(rv)
  );
  fsp_fault_pg #(.PWM_DIV(DIV)) fsp_fault_pg_inst (
    .SYS_CLK(clk), .RSTN(rstn), .CMD_CODE(code), .CMD_WR(wr), .CMD_WDATA(wd),
    .CMD_RD(rd), .CMD_RDATA(rdat), .CMD_RVALID(rv), .CLEAR_FAULTS(clr),
    .VENDOR_STATUS_BYTE(st[55:48]), .OTHER_STATUS_BYTE(st[47:40]),
    .COMM_STATUS_BYTE(st[39:32]), .TEMP_STATUS_BYTE(st[31:24]),
    .INPUT_STATUS_BYTE(st[23:16]), .LOAD_CURRENT_STATUS_BYTE(st[15:8]),
    .OUTPUT_VOLT_STATUS_BYTE(st[7:0]), .COMM_FAULT_BIT(cfb), .HOST_ALERT_N(alert_n),
    .PHASE_SEL(sel), .PHASE_REPORTS(rep), .PHASE_ASSIGNED(asg), .NVM_LOAD(nvm),
    .NVM_PWR_OK_SETTINGS(nvd), .PG_EVENTS(ev), .PG_EVENT_CONTINUE(cont), .CONV_EN(conv),
    .TURN_ON_WAIT(seqv[3]), .TURN_ON_RAMP(seqv[2]), .TURN_OFF_RAMP(seqv[1]),
    .FAULT_SHUTDOWN(seqv[0]), .POWER_OK_OUTPUT(pg)
  );
  // --
  // helpers
  // --
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic int dly(input int c);
    return (c == 0) ? 1 : (1 << c) + 1;
  endfunction : dly
  function automatic logic [55:0] ph_exp(input logic [7:0] s, input logic [3:0] f);
    if (s == 8'hff || s == 8'h80) return {52'h0, f};
    if (s < 8'h04) return {55'h0, f[s[1:0]]};
    return 56'h0;
  endfunction : ph_exp
  task automatic check(input logic [55:0] got, input logic [55:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic results();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results
  // tick phase unknown, so one tick of slack each way
  task automatic pg_dly(input logic v, input int c);
    int i;
    #1;
    for (i = 0; i < (dly(c) + 1) * DIV + 4 && pg !== v; i++) @(negedge clk);
    check(i >= (dly(c) - 1) * DIV, 1'b1);
    check(pg, v);
  endtask : pg_dly
  task automatic pg_stay(input logic v, input int n);
    repeat (n) begin
      @(negedge clk);
      check(pg, v);
    end
  endtask : pg_stay
  task automatic setcfg(input logic [15:0] v);
    @(negedge clk);
    conv = 1'b0;
    host.wr(8'he3, v);
    @(negedge clk);
    conv = 1'b1;
  endtask : setcfg
  // --
  // sequence
  // --
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200_000;
    failures++;
    results();
  end
  initial begin
    {seed, failures, n_checks} = {32'd15372, 64'd0};
    {rstn, clr, nvm, conv, st, sel, ev, cont, rep, asg, seqv, nvd} = '0;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    host.rd(8'he3, q);
    check(q, 56'h0);
    host.rd(8'hdc, q);
    check(q, 56'h0);
    check({cfb, alert_n}, 2'b01);
    @(negedge clk);
    nvd = 16'(rnd());
    nvm = 1'b1;
    @(negedge clk);
    nvm = 1'b0;
    conv = 1'b1;
    host.wr(8'he3, ~nvd);
    host.rd(8'he3, q);
    check(q, {40'h0, nvd});
    check(cfb, 1'b1);
    @(negedge clk);
    {conv, clr} = 2'b01;
    @(negedge clk);
    clr = 1'b0;
    host.wr(8'he3, ~nvd);
    host.rd(8'he3, q);
    check(q, {40'h0, ~nvd});
    inv = 1'b0;
    for (k = 0; k < 6; k++) begin
      if (k >= 2) host.wr(8'hdb, 16'(rnd()));
      inv = k >= 2;
      @(negedge clk);
      st = {rnd(), 24'(rnd())};
      host.rd(8'hdb, q);
      check(q, st | {16'h0, inv, 39'h0});
      check(cfb, inv || st[39:32] != 8'h00);
    end
    @(negedge clk);
    {st, clr} = {56'h0, 1'b1};
    @(negedge clk);
    clr = 1'b0;
    repeat (2) @(negedge clk);
    check({cfb, alert_n}, 2'b01);
    for (k = 0; k < 4; k++) begin
      @(negedge clk);
      {asg, rep} = 8'(rnd());
      stk = rep;
      @(negedge clk);
      rep = 4'h0;
      for (j = 0; j < 7; j++) begin
        sel = sels[j];
        host.rd(8'hdc, q);
        check(q, ph_exp(sels[j], stk & asg));
      end
      sel = 8'hff;
      w = 4'(rnd());
      host.wr(8'hdc, {12'h0, w});
      host.rd(8'hdc, q);
      check(q, {52'h0, stk & asg & ~w});
      host.wr(8'hdc, 16'h000f);
    end
    setcfg(16'h2100);
    pg_dly(1'b1, 1);
    @(negedge clk);
    ev = 8'h04;
    pg_dly(1'b0, 2);
    @(negedge clk);
    ev = 8'h00;
    pg_dly(1'b1, 1);
    for (k = 0; k < 8; k++) begin
      setcfg({8'h00, 8'h01 << k});
      pg_dly(1'b1, 0);
      @(negedge clk);
      ev = (8'h01 << k) | (8'h01 << ((k + 1) % 8));
      cont = 8'h01 << ((k + 1) % 8);
      pg_stay(1'b1, 8);
      @(negedge clk);
      cont = 8'h00;
      pg_dly(1'b0, 0);
      @(negedge clk);
      ev = 8'h00;
    end
    setcfg(16'h3000);
    pg_dly(1'b1, 0);
    @(negedge clk);
    ev = 8'h80;
    repeat (4) @(negedge clk);
    ev = 8'h00;
    pg_stay(1'b1, 24);
    // long fault-to-low delay makes a missing bypass show
    setcfg(16'hf000);
    pg_dly(1'b1, 0);
    for (k = 0; k < 5; k++) begin
      @(negedge clk);
      seqv = 4'h8 >> k;
      conv = k != 4;
      ev = (k == 2 || k == 3) ? 8'h01 : 8'h00;
      pg_stay(1'b0, 2);
      @(negedge clk);
      {seqv, conv} = 5'h01;
      if (ev[0]) pg_stay(1'b0, 4);
      @(negedge clk);
      ev = 8'h00;
      pg_dly(1'b1, 0);
    end
    @(negedge clk);
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    host.rd(8'he3, q);
    check(q, 56'h0);
    results();
  end
endmodule : fsp_fault_pg_test
